// [fe_tx_regs.svh]
// Constants of the fast Ethernet transmit coding path: code-groups,
// scrambler layout, symbol framing and settle timing.
// Assumes inclusion by bare name; holds definitions only.
`ifndef FE_TX_REGS_SVH
`define FE_TX_REGS_SVH

// Data code-groups, nibble 0 to F
`define CG_D0 5'h1E
`define CG_D1 5'h09
`define CG_D2 5'h14
`define CG_D3 5'h15
`define CG_D4 5'h0A
`define CG_D5 5'h0B
`define CG_D6 5'h0E
`define CG_D7 5'h0F
`define CG_D8 5'h12
`define CG_D9 5'h13
`define CG_DA 5'h16
`define CG_DB 5'h17
`define CG_DC 5'h1A
`define CG_DD 5'h1B
`define CG_DE 5'h1C
`define CG_DF 5'h1D

// Control code-groups
`define CG_HALT 5'h04
`define CG_IDLE 5'h1F
`define CG_SSD_J 5'h18
`define CG_SSD_K 5'h11
`define CG_ESD_T 5'h0D
`define CG_ESD_R 5'h07

// Invalid code-groups
`define CG_V0 5'h00
`define CG_V1 5'h01
`define CG_V2 5'h02
`define CG_V3 5'h03
`define CG_V5 5'h05
`define CG_V6 5'h06
`define CG_V8 5'h08
`define CG_VC 5'h0C

// Nibbles shown by the decoder for control and bad groups
`define NIB_PREAMBLE 4'h5
`define NIB_ZERO 4'h0
`define NIB_BAD 4'hE

// Symbol framing: five line bits, most significant first
`define SYM_BITS 5
`define SYM_LAST 3'h4

// Scrambler x^11 + x^9 + 1
`define SCR_WIDTH 11
`define SCR_TAP_HI 10
`define SCR_TAP_LO 8

// MLT-3 phases
`define MLT_ZERO_A 2'h0
`define MLT_PLUS 2'h1
`define MLT_ZERO_B 2'h2
`define MLT_MINUS 2'h3

// Strap settle time after reset, and the clock period
`define CLK_PERIOD_NS 10
`define STRAP_SETTLE_NS 30
`define STRAP_SETTLE_CYC ((`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Pin synchroniser latency: three stages plus the agreement register
`define PIN_SYNC_CYC 4

// FIFO depth in nibbles
`define TX_FIFO_DEPTH 8

`endif

// [fe_tx_pkg.sv]
// Types of the fast Ethernet transmit coding path.
// Assumes fe_tx_regs.svh for the numeric constants.
package fe_tx_pkg;

  // One MII nibble as it travels through the FIFO
  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] data;
  } tx_entry_t;

  // One decoded receive code-group
  typedef struct packed {
    logic valid;
    logic er;
    logic [3:0] nibble;
  } rx_decode_t;

  // Transmit framing states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SSD_K = 4'b0010,
    ST_DATA = 4'b0100,
    ST_ESD_R = 4'b1000
  } tx_state_t;

endpackage

// [tx_nibble_fifo.sv]
// Nibble FIFO with a registered output stage, valid/ready on both sides.
// Assumes one clock; holds DEPTH entries in store plus one at the output.
`timescale 1ns/10ps
`default_nettype none

module tx_nibble_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pull;

  // Store fills only while room remains; the output stage pulls from store
  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign push = in_valid & in_ready;
  assign pull = (count_q != '0) & (~out_valid | out_ready);

  // Storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pull) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pull);
    end
  end

  // Registered head, so the consumer sees data from a flip-flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pull) begin
      out_valid <= 1'b1;
      out_data <= mem_q[rd_ptr_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule // tx_nibble_fifo

`default_nettype wire

// [code_group_decoder.sv]
// Receive 5B code-group classifier with a registered answer.
// Assumes aligned code-groups and a data-field flag from the receive path.
`timescale 1ns/10ps
`default_nettype none
`include "fe_tx_regs.svh"

module code_group_decoder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] code,
  input wire logic code_valid,
  input wire logic in_data,
  output fe_tx_pkg::rx_decode_t result
);
  import fe_tx_pkg::*;

  rx_decode_t res_d;

  // Lookup of one code-group
  always_comb begin
    res_d = '{valid: code_valid, er: 1'b0, nibble: `NIB_ZERO};
    case (code)
      `CG_D0: res_d.nibble = 4'h0;
      `CG_D1: res_d.nibble = 4'h1;
      `CG_D2: res_d.nibble = 4'h2;
      `CG_D3: res_d.nibble = 4'h3;
      `CG_D4: res_d.nibble = 4'h4;
      `CG_D5: res_d.nibble = 4'h5;
      `CG_D6: res_d.nibble = 4'h6;
      `CG_D7: res_d.nibble = 4'h7;
      `CG_D8: res_d.nibble = 4'h8;
      `CG_D9: res_d.nibble = 4'h9;
      `CG_DA: res_d.nibble = 4'hA;
      `CG_DB: res_d.nibble = 4'hB;
      `CG_DC: res_d.nibble = 4'hC;
      `CG_DD: res_d.nibble = 4'hD;
      `CG_DE: res_d.nibble = 4'hE;
      `CG_DF: res_d.nibble = 4'hF;
      `CG_SSD_J, `CG_SSD_K: begin
        res_d.nibble = in_data ? `NIB_BAD : `NIB_PREAMBLE;
        res_d.er = in_data;
      end
      `CG_IDLE, `CG_ESD_T, `CG_ESD_R: begin
        res_d.nibble = in_data ? `NIB_BAD : `NIB_ZERO;
        res_d.er = in_data;
      end
      `CG_HALT: begin
        res_d.nibble = `NIB_BAD;
        res_d.er = 1'b1;
      end
      `CG_V0, `CG_V1, `CG_V2, `CG_V3, `CG_V5, `CG_V6, `CG_V8, `CG_VC: begin
        res_d.nibble = `NIB_BAD;
        res_d.er = 1'b1;
      end
      default: begin
        res_d.nibble = `NIB_BAD;
        res_d.er = 1'b1;
      end
    endcase
    if (!code_valid) begin
      res_d.er = 1'b0;
      res_d.nibble = `NIB_ZERO;
    end
  end

  // Answer held in a register, one cycle after the code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= '0;
    end else begin
      result <= res_d;
    end
  end

endmodule // code_group_decoder

`default_nettype wire

// [fe_tx_line_encoder.sv]
// Fast Ethernet transmit coding path: MII nibbles to two MLT-3 drive phases.
// Assumes the MAC logic runs on MCLK; straps and bypass pins are asynchronous.
// One line bit leaves per MCLK edge, so MCLK is the code-bit clock.
`timescale 1ns/10ps
`default_nettype none
`include "fe_tx_regs.svh"

module fe_tx_line_encoder #(
  parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [3:0] TXD,
  input wire logic TX_EN,
  input wire logic TX_ER,
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire logic [4:0] PHY_ADDRESS_STRAPS,
  input wire logic BYPASS_ENCODER,
  input wire logic BYPASS_SCRAMBLER,
  input wire logic BYPASS_NRZI,
  output logic TX_DRIVE_POS,
  output logic TX_DRIVE_NEG,
  output logic TX_ACTIVE,
  output logic [4:0] TX_CODE_GROUP,
  input wire logic [4:0] RX_CODE,
  input wire logic RX_CODE_VALID,
  input wire logic RX_IN_DATA,
  output logic [3:0] RX_NIBBLE,
  output logic RX_NIBBLE_VALID,
  output logic RX_ER
);
  import fe_tx_pkg::*;

  localparam int PIN_W = 8;
  localparam int SETTLE_W = 4;
  // Seed waits out the synchroniser too, otherwise it would read the reset zeros
  localparam logic [SETTLE_W-1:0] SETTLE_CYC = SETTLE_W'(`STRAP_SETTLE_CYC + `PIN_SYNC_CYC);

  // Pin bundle: straps in the low five bits, bypass selects above
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic [PIN_W-1:0] pin_s3_q;
  logic [PIN_W-1:0] pin_q;
  logic [4:0] straps;
  logic byp_enc;
  logic byp_scr;
  logic byp_nrzi;

  assign pin_raw = {BYPASS_NRZI, BYPASS_SCRAMBLER, BYPASS_ENCODER, PHY_ADDRESS_STRAPS};
  assign straps = pin_q[4:0];
  assign byp_enc = pin_q[5];
  assign byp_scr = pin_q[6];
  assign byp_nrzi = pin_q[7];

  // Three-stage synchroniser per pin; a change is taken once stages two and three agree
  for (genvar i = 0; i < PIN_W; i++) begin : g_pin_sync
    always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
        pin_s1_q[i] <= 1'b0;
        pin_s2_q[i] <= 1'b0;
        pin_s3_q[i] <= 1'b0;
        pin_q[i] <= 1'b0;
      end else begin
        pin_s1_q[i] <= pin_raw[i];
        pin_s2_q[i] <= pin_s1_q[i];
        pin_s3_q[i] <= pin_s2_q[i];
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // Write side of the FIFO
  tx_entry_t wr_entry;
  tx_entry_t head;
  logic [$bits(tx_entry_t)-1:0] head_raw;
  logic wr_valid;
  logic wr_ready;
  logic head_valid;
  logic pop;
  logic en_seen_q;

  // frame held by TX_EN: only frame nibbles and one closing marker enter the FIFO
  assign wr_valid = TX_VALID & (TX_EN | en_seen_q);
  assign wr_entry = '{en: TX_EN, er: TX_ER & TX_EN, data: TXD};
  assign TX_READY = wr_ready;
  assign head = tx_entry_t'(head_raw);

  // Remembers an open frame so the falling TX_EN leaves one marker entry
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      en_seen_q <= 1'b0;
    end else if (wr_valid & wr_ready) begin
      en_seen_q <= TX_EN;
    end
  end

  // Nibble buffer; a full buffer stalls the MAC through TX_READY
  tx_nibble_fifo #(
    .WIDTH($bits(tx_entry_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst_n(RSTN),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_entry),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head_raw)
  );

  function automatic logic [4:0] enc_4b5b(input logic [3:0] nib);
    logic [4:0] cg;
    case (nib)
      4'h0: cg = `CG_D0;
      4'h1: cg = `CG_D1;
      4'h2: cg = `CG_D2;
      4'h3: cg = `CG_D3;
      4'h4: cg = `CG_D4;
      4'h5: cg = `CG_D5;
      4'h6: cg = `CG_D6;
      4'h7: cg = `CG_D7;
      4'h8: cg = `CG_D8;
      4'h9: cg = `CG_D9;
      4'hA: cg = `CG_DA;
      4'hB: cg = `CG_DB;
      4'hC: cg = `CG_DC;
      4'hD: cg = `CG_DD;
      4'hE: cg = `CG_DE;
      default: cg = `CG_DF;
    endcase
    return cg;
  endfunction

  // Seed capture after reset release, once straps have passed the synchroniser
  logic [SETTLE_W-1:0] settle_q;
  logic seeded_q;
  logic seed_load;

  assign seed_load = ~seeded_q & (settle_q == SETTLE_CYC);

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      settle_q <= '0;
      seeded_q <= 1'b0;
    end else if (!seeded_q) begin
      settle_q <= settle_q + 1'b1;
      seeded_q <= seed_load;
    end
  end

  // Symbol timing: a new code-group is chosen on the last bit of the current one
  logic [2:0] bit_cnt_q;
  logic sym_tick;

  assign sym_tick = (bit_cnt_q == `SYM_LAST);

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      bit_cnt_q <= '0;
    end else begin
      bit_cnt_q <= sym_tick ? 3'h0 : bit_cnt_q + 1'b1;
    end
  end

  // Framing state machine
  tx_state_t state_q;
  tx_state_t state_d;
  logic [4:0] sym_d;
  logic [4:0] data_sym;

  // encoder bypass sends TX_ER and the raw nibble as five bits
  assign data_sym = byp_enc ? {head.er, head.data} :
                    head.er ? `CG_HALT : enc_4b5b(head.data);

  always_comb begin
    state_d = state_q;
    sym_d = `CG_IDLE;
    pop = 1'b0;
    if (sym_tick & seeded_q) begin
      case (state_q)
        ST_IDLE: begin
          if (head_valid & head.en) begin
            sym_d = `CG_SSD_J;
            pop = 1'b1;
            state_d = ST_SSD_K;
          end else begin
            sym_d = `CG_IDLE;
            pop = head_valid;
          end
        end
        ST_SSD_K: begin
          sym_d = `CG_SSD_K;
          pop = head_valid & head.en;
          state_d = ST_DATA;
        end
        ST_DATA: begin
          if (!head_valid) begin
            // underrun is signalled with the halt group
            sym_d = `CG_HALT;
          end else if (head.en) begin
            sym_d = data_sym;
            pop = 1'b1;
          end else begin
            // end of frame begins with T
            sym_d = `CG_ESD_T;
            pop = 1'b1;
            state_d = ST_ESD_R;
          end
        end
        ST_ESD_R: begin
          sym_d = `CG_ESD_R;
          state_d = ST_IDLE;
        end
        default: begin
          sym_d = `CG_IDLE;
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // serialiser: five bits per group, most significant first
  logic [4:0] shift_q;
  logic nrz_bit;

  assign nrz_bit = shift_q[4];

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      shift_q <= `CG_IDLE;
      TX_CODE_GROUP <= `CG_IDLE;
      TX_ACTIVE <= 1'b0;
    end else if (sym_tick) begin
      shift_q <= sym_d;
      TX_CODE_GROUP <= sym_d;
      TX_ACTIVE <= (sym_d != `CG_IDLE);
    end else begin
      shift_q <= {shift_q[3:0], 1'b0};
    end
  end

  // Scrambler; an all-ones top bit keeps the seed off the locked all-zero state
  logic [`SCR_WIDTH-1:0] lfsr_q;
  logic key_bit;
  logic scr_q;

  // taps of x^11 + x^9 + 1
  assign key_bit = lfsr_q[`SCR_TAP_HI] ^ lfsr_q[`SCR_TAP_LO];

  // seed from straps, then one step per line bit
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      lfsr_q <= {`SCR_WIDTH{1'b1}};
    end else if (seed_load) begin
      lfsr_q <= {1'b1, straps, ~straps};
    end else begin
      lfsr_q <= {lfsr_q[`SCR_WIDTH-2:0], key_bit};
    end
  end

  // key XORed onto the serial stream, scrambler bypass
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      scr_q <= 1'b0;
    end else begin
      scr_q <= byp_scr ? nrz_bit : (nrz_bit ^ key_bit);
    end
  end

  // NRZI: a one toggles the level; bypass takes the stream as NRZI already
  logic nrzi_q;
  logic nrzi_prev_q;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      nrzi_q <= 1'b0;
      nrzi_prev_q <= 1'b0;
    end else begin
      nrzi_q <= byp_nrzi ? scr_q : (nrzi_q ^ scr_q);
      nrzi_prev_q <= nrzi_q;
    end
  end

  // MLT-3 phase walks zero, plus, zero, minus on each NRZI transition
  logic [1:0] phase_q;
  logic [1:0] phase_d;

  assign phase_d = (nrzi_q ^ nrzi_prev_q) ? phase_q + 2'h1 : phase_q;

  // ones alternate between the two drive streams
  // no stage bypasses this split, so the line is always three-level
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      phase_q <= `MLT_ZERO_A;
      TX_DRIVE_POS <= 1'b0;
      TX_DRIVE_NEG <= 1'b0;
    end else begin
      phase_q <= phase_d;
      TX_DRIVE_POS <= (phase_d == `MLT_PLUS);
      TX_DRIVE_NEG <= (phase_d == `MLT_MINUS);
    end
  end

  // Receive code-group classifier
  rx_decode_t rx_res;

  // control groups in data raise RX_ER, invalid groups likewise
  code_group_decoder u_decoder (
    .clk(MCLK),
    .rst_n(RSTN),
    .code(RX_CODE),
    .code_valid(RX_CODE_VALID),
    .in_data(RX_IN_DATA),
    .result(rx_res)
  );

  assign RX_NIBBLE = rx_res.nibble;
  assign RX_NIBBLE_VALID = rx_res.valid;
  assign RX_ER = rx_res.er;

endmodule // fe_tx_line_encoder

`default_nettype wire

// [fe_tx_line_encoder_sva.sv]
// Checker of the transmit coding path: drive phases, framing, decoder.
// Assumes binding to fe_tx_line_encoder; one clock MCLK, reset RSTN.
`timescale 1ns/10ps
`default_nettype none

module fe_tx_line_encoder_sva (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic TX_READY,
  input wire logic TX_DRIVE_POS,
  input wire logic TX_DRIVE_NEG,
  input wire logic [4:0] TX_CODE_GROUP,
  input wire logic [4:0] RX_CODE,
  input wire logic RX_CODE_VALID,
  input wire logic RX_IN_DATA,
  input wire logic [3:0] RX_NIBBLE,
  input wire logic RX_NIBBLE_VALID,
  input wire logic RX_ER
);
  logic last_neg_q;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // Polarity of the last pulse; reset leaves the phase so plus comes first
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) last_neg_q <= 1'b1;
    else if (TX_DRIVE_NEG) last_neg_q <= 1'b1;
    else if (TX_DRIVE_POS) last_neg_q <= 1'b0;
  end
  a_drive_excl: assert property (!(TX_DRIVE_POS && TX_DRIVE_NEG))
    else $error("both drive phases high");
  a_zero_between: assert property ($rose(TX_DRIVE_NEG) |-> !$past(TX_DRIVE_POS))
    else $error("plus went straight to minus");
  a_phase_alternate: assert property ($rose(TX_DRIVE_POS) |-> last_neg_q)
    else $error("two plus pulses in a row");
  a_symbol_hold: assert property ($changed(TX_CODE_GROUP) |=> $stable(TX_CODE_GROUP)[*4])
    else $error("code-group shorter than five bits");
  a_start_pair: assert property ($changed(TX_CODE_GROUP) && TX_CODE_GROUP == 5'h18
    |-> ##5 TX_CODE_GROUP == 5'h11) else $error("J not followed by K");
  a_end_pair: assert property ($changed(TX_CODE_GROUP) && TX_CODE_GROUP == 5'h0D
    |-> ##5 TX_CODE_GROUP == 5'h07) else $error("T not followed by R");
  a_idle_after: assert property ($changed(TX_CODE_GROUP) && TX_CODE_GROUP == 5'h07
    |-> ##5 TX_CODE_GROUP inside {5'h1F, 5'h18}) else $error("no idle after R");
  a_rx_quiet: assert property (!RX_CODE_VALID |=> !RX_NIBBLE_VALID && !RX_ER)
    else $error("decoder answered without a code");
  a_rx_ctrl_data: assert property (RX_CODE_VALID && RX_IN_DATA
    && RX_CODE inside {5'h1F, 5'h18, 5'h11, 5'h0D, 5'h07}
    |=> RX_ER && RX_NIBBLE == 4'hE) else $error("control group in data not flagged");
  a_rx_invalid: assert property (RX_CODE_VALID
    && RX_CODE inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C}
    |=> RX_ER && RX_NIBBLE == 4'hE) else $error("invalid group not flagged");
  a_rx_halt: assert property (RX_CODE_VALID && RX_CODE == 5'h04 |=> RX_ER)
    else $error("halt group not flagged");
  a_rx_data_ok: assert property (RX_CODE_VALID && RX_CODE == 5'h1D
    |=> !RX_ER && RX_NIBBLE_VALID && RX_NIBBLE == 4'hF) else $error("data group F wrong");
  c_start: cover property ($changed(TX_CODE_GROUP) && TX_CODE_GROUP == 5'h18);
  c_halt: cover property (TX_CODE_GROUP == 5'h04);
  c_full: cover property (!TX_READY);
  c_rx_er: cover property (RX_ER);
endmodule // fe_tx_line_encoder_sva

bind fe_tx_line_encoder fe_tx_line_encoder_sva i_fe_tx_line_encoder_sva (
  .MCLK(MCLK), .RSTN(RSTN), .TX_READY(TX_READY), .TX_DRIVE_POS(TX_DRIVE_POS),
  .TX_DRIVE_NEG(TX_DRIVE_NEG), .TX_CODE_GROUP(TX_CODE_GROUP), .RX_CODE(RX_CODE),
  .RX_CODE_VALID(RX_CODE_VALID), .RX_IN_DATA(RX_IN_DATA), .RX_NIBBLE(RX_NIBBLE),
  .RX_NIBBLE_VALID(RX_NIBBLE_VALID), .RX_ER(RX_ER));
`default_nettype wire

// [mii_mac_model.sv]
// MAC-side model: offers MII nibbles with valid and holds them until taken.
// Assumes the encoder takes a nibble on the rising edge with ready high.
`timescale 1ns/10ps
`default_nettype none

module mii_mac_model (
  input wire logic clk,
  input wire logic tx_ready,
  output logic [3:0] txd,
  output logic tx_en,
  output logic tx_er,
  output logic tx_valid
);
  initial begin
    txd = 4'h0;
    tx_en = 1'b0;
    tx_er = 1'b0;
    tx_valid = 1'b0;
  end
  // one nibble per beat
  // Change just after an edge, hold until the edge that samples ready high
  task automatic put(input logic [3:0] d, input logic en, input logic er);
    #1;
    txd = d;
    tx_en = en;
    tx_er = er;
    tx_valid = 1'b1;
    do @(posedge clk); while (tx_ready !== 1'b1);
  endtask
  // Released lines show the inverse, never a stale nibble
  task automatic drop_bus();
    #1;
    tx_valid = 1'b0;
    txd = ~txd;
  endtask
endmodule // mii_mac_model
`default_nettype wire

// [fe_tx_line_encoder_tb.sv]
// Testbench of the transmit coding path: frames, halt, decoder, line phases.
// Assumes the MAC model on the MII side; the checker is bound separately.
`timescale 1ns/10ps
`default_nettype none

module fe_tx_line_encoder_tb;
  logic mclk = 1'b0;
  logic rstn, tx_en, tx_er, tx_valid, tx_ready, byp_enc, byp_scr, byp_nrzi;
  logic drv_pos, drv_neg, tx_active, rx_code_valid, rx_in_data, rx_nib_valid, rx_er;
  logic [3:0] txd, rx_nib;
  logic [4:0] straps, code_grp, rx_code, last_cg;
  logic [4:0] got_q[$], exp_q[$];
  logic [3:0] nib_q[$];
  logic [4:0] dtab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  int error_cnt, n_tests, cycles, act_cnt;
  bit rec, saw_full;

  fe_tx_line_encoder #(.FIFO_DEPTH(8)) i_fe_tx_line_encoder (.MCLK(mclk), .RSTN(rstn),
    .TXD(txd), .TX_EN(tx_en), .TX_ER(tx_er), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .PHY_ADDRESS_STRAPS(straps), .BYPASS_ENCODER(byp_enc), .BYPASS_SCRAMBLER(byp_scr),
    .BYPASS_NRZI(byp_nrzi), .TX_DRIVE_POS(drv_pos), .TX_DRIVE_NEG(drv_neg),
    .TX_ACTIVE(tx_active), .TX_CODE_GROUP(code_grp), .RX_CODE(rx_code),
    .RX_CODE_VALID(rx_code_valid), .RX_IN_DATA(rx_in_data), .RX_NIBBLE(rx_nib),
    .RX_NIBBLE_VALID(rx_nib_valid), .RX_ER(rx_er));
  mii_mac_model i_mii_mac_model (.clk(mclk), .tx_ready(tx_ready), .txd(txd),
    .tx_en(tx_en), .tx_er(tx_er), .tx_valid(tx_valid));

  always #5 mclk = ~mclk;

  // Symbol log by change, so frames use neighbouring groups that differ
  always @(posedge mclk) begin
    cycles++;
    if (tx_ready === 1'b0) saw_full = 1'b1;
    if (rec && tx_active === 1'b1) act_cnt++;
    if (rec && code_grp !== last_cg) begin
      got_q.push_back(code_grp);
      last_cg = code_grp;
    end
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Own decoder table: control groups other than halt are errors only inside data
  function automatic logic [4:0] exp_rx(input logic [5:0] v);
    logic [4:0] r;
    r = 5'h1E;
    for (int k = 0; k < 16; k++) if (dtab[k] == v[4:0]) r = {1'b0, 4'(k)};
    if (v[4:0] == 5'h18 || v[4:0] == 5'h11) r = v[5] ? 5'h1E : 5'h05;
    if (v[4:0] inside {5'h1F, 5'h0D, 5'h07}) r = v[5] ? 5'h1E : 5'h00;
    return r;
  endfunction

  // Sends nib_q as one frame plus an end marker, compares the symbol log
  task automatic run_frame(input int er_at);
    int k;
    got_q = {};
    last_cg = 5'h1F;
    saw_full = 1'b0;
    act_cnt = 0;
    rec = 1'b1;
    @(posedge mclk);
    foreach (nib_q[i]) i_mii_mac_model.put(nib_q[i], 1'b1, i == er_at);
    i_mii_mac_model.put(4'h0, 1'b0, 1'b0);
    i_mii_mac_model.drop_bus();
    k = 0;
    while (got_q.size() < exp_q.size() + 1 && k < 800) begin
      @(posedge mclk);
      k++;
    end
    rec = 1'b0;
    chk("symbol count", 5'(exp_q.size() + 1), 5'(got_q.size()));
    chk("active cycles", 5'h01, {4'h0, act_cnt == exp_q.size() * 5});
    foreach (exp_q[i]) chk("code group", exp_q[i], got_q[i]);
    chk("idle after frame", 5'h1F, got_q[exp_q.size()]);
    repeat (10) @(posedge mclk);
    #1;
    chk("active after frame", 5'h00, {4'h0, tx_active});
  endtask

  task automatic scen_idle();
    chk("idle group", 5'h1F, code_grp);
    chk("idle active", 5'h00, {4'h0, tx_active});
  endtask

  // Sixteen data nibbles back to back: every data group, FIFO fills
  task automatic scen_full_frame();
    nib_q = {4'h5, 4'h5};
    exp_q = {5'h18, 5'h11};
    for (int i = 0; i < 16; i++) begin
      nib_q.push_back(4'(i));
      exp_q.push_back(dtab[i]);
    end
    exp_q.push_back(5'h0D);
    exp_q.push_back(5'h07);
    run_frame(-1);
    chk("fifo refused", 5'h01, {4'h0, saw_full});
    chk("fifo drained", 5'h01, {4'h0, tx_ready});
  endtask

  // TX_ER sends halt; with the encoder bypassed it rides as the top bit instead
  task automatic scen_halt();
    nib_q = {4'h5, 4'h5, 4'h3, 4'hA, 4'h6};
    exp_q = {5'h18, 5'h11, 5'h15, 5'h04, 5'h0E, 5'h0D, 5'h07};
    run_frame(3);
    byp_enc = 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    nib_q = {4'h5, 4'h5, 4'h1, 4'h2, 4'h3};
    exp_q = {5'h18, 5'h11, 5'h01, 5'h12, 5'h03, 5'h0D, 5'h07};
    run_frame(3);
    byp_enc = 1'b0;
  endtask

  task automatic scen_rx_table();
    logic [4:0] e;
    @(posedge mclk);
    #1;
    for (int i = 0; i < 64; i++) begin
      rx_code = i[4:0];
      rx_in_data = i[5];
      rx_code_valid = 1'b1;
      e = exp_rx(i[5:0]);
      @(posedge mclk);
      #1;
      chk("rx er and nibble", e, {rx_er, rx_nib});
      chk("rx valid", 5'h01, {4'h0, rx_nib_valid});
    end
    rx_code_valid = 1'b0;
    rx_code = ~rx_code;
    @(posedge mclk);
    #1;
    chk("rx quiet", 5'h00, {rx_er, rx_nib});
  endtask

  // Unscrambled idle is all ones: NRZI turns each bit, phase steps every cycle
  task automatic scen_line_phase();
    logic p0, n0;
    int j;
    @(posedge mclk);
    #1;
    byp_scr = 1'b1;
    repeat (40) @(posedge mclk);
    #1;
    j = 0;
    while (drv_pos !== 1'b1 && j < 20) begin
      @(posedge mclk);
      #1;
      j++;
    end
    for (int i = 1; i <= 8; i++) begin
      @(posedge mclk);
      #1;
      chk("plus phase", {4'h0, i % 4 == 0}, {4'h0, drv_pos});
      chk("minus phase", {4'h0, i % 4 == 2}, {4'h0, drv_neg});
    end
    // With NRZI bypassed a constant stream never moves the phase
    byp_nrzi = 1'b1;
    repeat (40) @(posedge mclk);
    #1;
    p0 = drv_pos;
    n0 = drv_neg;
    repeat (8) @(posedge mclk);
    #1;
    chk("held phase", {3'h0, p0, n0}, {3'h0, drv_pos, drv_neg});
    byp_scr = 1'b0;
    byp_nrzi = 1'b0;
  endtask

  // Scrambled idle after a mid-run reset: other straps, other line; same straps, same line
  task automatic scen_seed();
    logic [127:0] sig [3];
    for (int s = 0; s < 3; s++) begin
      straps = (s == 1) ? 5'h0A : 5'h15;
      rstn = 1'b0;
      repeat (8) @(posedge mclk);
      #1 rstn = 1'b1;
      repeat (30) @(posedge mclk);
      for (int c = 0; c < 64; c++) begin
        @(posedge mclk);
        #1;
        sig[s] = {sig[s][125:0], drv_pos, drv_neg};
      end
    end
    chk("seed differs", 5'h01, {4'h0, sig[0] != sig[1]});
    chk("seed repeats", 5'h01, {4'h0, sig[0] === sig[2]});
  endtask

  initial begin
    rstn = 1'b0;
    straps = 5'h15;
    byp_enc = 1'b0;
    byp_scr = 1'b0;
    byp_nrzi = 1'b0;
    rx_code = 5'h00;
    rx_code_valid = 1'b0;
    rx_in_data = 1'b0;
    rec = 1'b0;
    last_cg = 5'h1F;
    error_cnt = 0;
    n_tests = 0;
    cycles = 0;
    repeat (8) @(posedge mclk);
    #1 rstn = 1'b1;
    repeat (20) @(posedge mclk);
    #1;
    scen_idle();
    scen_full_frame();
    scen_halt();
    scen_rx_table();
    scen_line_phase();
    scen_seed();
    print_verdict();
  end
endmodule // fe_tx_line_encoder_tb
`default_nettype wire
